// ---- design/vpc_pkg.sv ----
// Constants, register map and state types of the vacuum pump controller
package vpc_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ      = 50_000_000;
    localparam int MS_PER_S    = 1000;
    localparam int CYC_PER_MS  = CLK_HZ / MS_PER_S;
    localparam int IN_REACT_MS = 3;
    localparam int SAVE_WIN_S  = 3;
    localparam int MENU_IDLE_S = 60;
    localparam int FLASH_MS    = 250;

    // ----------------------------------------------------------------
    // Limits and regulation band
    // ----------------------------------------------------------------
    localparam logic [15:0] UNDER_MV = 16'h4B00;  // 19.2 V
    localparam logic [15:0] OVER_MV  = 16'h6720;  // 26.4 V
    localparam logic [13:0] BAND_NUM = 14'h0009;  // Restart at 90 %
    localparam logic [13:0] BAND_DEN = 14'h000A;
    localparam logic [7:0]  DLY_MIN  = 8'h01;
    localparam logic [7:0]  DLY_MAX  = 8'hC8;     // 200 ms

    // ----------------------------------------------------------------
    // Register map, word index (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_CTRL   = 6'h00;
    localparam logic [5:0] IDX_STOP   = 6'h01;
    localparam logic [5:0] IDX_PART   = 6'h02;
    localparam logic [5:0] IDX_HYST   = 6'h03;
    localparam logic [5:0] IDX_BLOW   = 6'h04;
    localparam logic [5:0] IDX_DLY    = 6'h05;
    localparam logic [5:0] IDX_STATUS = 6'h06;
    localparam logic [5:0] IDX_VAC    = 6'h07;
    localparam logic [5:0] IDX_SUPPLY = 6'h08;
    localparam logic [5:0] IDX_ENERGY = 6'h09;

    localparam int CTRL_NPN    = 0;
    localparam int CTRL_BLOINT = 1;
    localparam int CTRL_MANUAL = 2;
    localparam int STAT_SAVE   = 6;

    localparam logic [2:0]  CTRL_RST = 3'h0;      // PNP, external blowoff
    localparam logic [9:0]  STOP_RST = 10'h226;   // 550 mbar
    localparam logic [9:0]  PART_RST = 10'h190;   // 400 mbar
    localparam logic [9:0]  HYST_RST = 10'h014;   // 20 mbar
    localparam logic [15:0] BLOW_RST = 16'h00C8;  // 200 ms
    localparam logic [7:0]  DLY_RST  = 8'h0A;     // 10 ms

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        VPC_IDLE  = 4'b0001,
        VPC_SUCK  = 4'b0010,
        VPC_HOLD  = 4'b0100,
        VPC_BLOW  = 4'b1000
    } vpc_state_t;

    typedef struct packed {
        vpc_state_t  st;
        logic [2:0]  ctrl;
        logic [9:0]  thr_stop;
        logic [9:0]  thr_part;
        logic [9:0]  hyst;
        logic [15:0] blow_ms;
        logic [7:0]  dly_ms;
        logic [9:0]  vac;
        logic [15:0] ms_cnt;
        logic [3:0]  flt_cnt;
        logic [1:0]  in_act;
        logic [15:0] blow_cnt;
        logic        lvl_part;
        logic        lvl_stop;
        logic [7:0]  out_cnt;
        logic        second_switch_output;
        logic        second_switch_output_pin;
        logic        pump;
        logic        valve;
        logic        led_suck;
        logic        led_blow;
        logic        led_part;
        logic        led_stop;
        logic        under;
        logic        over;
        logic        save_err;
        logic [15:0] win_cnt;
        logic [15:0] menu_cnt;
        logic        menu_open;
        logic [7:0]  flash_cnt;
        logic        flash;
        logic [31:0] energy_ms;
        logic        ack;
        logic [31:0] dat;
    } vpc_regs_t;

endpackage

// ---- design/vpc_top.sv ----
// Vacuum pump controller: suction, regulation, blowoff, LEDs, supervision
// How it works
// - Pump follows the suction input, subject to regulation and blowoff.
// - In suction, pump stops once vacuum reaches the stop threshold.
// - Pump restarts once vacuum falls ten percent below the stop threshold.
// - Undervoltage flag while supply is below 19.2 V.
// - Overvoltage flag while supply is above 26.4 V.
// - External blowoff lasts exactly as long as the blowoff input.
// - Internal blowoff vents for a set time after suction ends.
// - Both inputs active means blowoff, suction suppressed.
// - Input and output polarity selectable PNP or NPN, PNP after reset.
// - Power loss within three seconds of a remote write sets save error.
// - Suction LED in suction or hold, blowoff LED while venting.
// - Rising vacuum: LEDs off, part-present only, then both.
// - Falling vacuum: hysteresis bands on the part and stop thresholds.
// - Manual mode flashes both threshold LEDs.
// - Outside manual mode, threshold LEDs depend on measured vacuum only.
// - Vacuum drives regulation, second switch output and energy data.
// - Panel may edit parameters only without a link session.
// - Link side writes parameters and reads measured vacuum.
// - Wireless tag writes count as parameter changes; tag works unpowered.
// - Inputs react after 3 ms; output delay adjustable 1 to 200 ms.
// - Menu closes after one minute without a settings action.
`timescale 1ns/10ps
module vpc_top
    import vpc_pkg::*;
#(
    parameter int P_CYC_PER_MS = CYC_PER_MS,
    parameter int P_SAVE_MS    = SAVE_WIN_S * MS_PER_S,
    parameter int P_MENU_MS    = MENU_IDLE_S * MS_PER_S
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        suction_i,
    input  wire logic        blowoff_i,
    input  wire logic [9:0]  vacuum_i,
    input  wire logic [15:0] supply_mv_i,
    input  wire logic        power_fail_i,
    input  wire logic        link_active_i,
    input  wire logic        wireless_write_i,
    input  wire logic        panel_key_i,
    input  wire logic        panel_we_i,
    input  wire logic [5:0]  panel_idx_i,
    input  wire logic [15:0] panel_dat_i,
    output logic             pump_o,
    output logic             valve_o,
    output logic             second_switch_output_o,
    output logic             led_suction_o,
    output logic             led_blowoff_o,
    output logic             led_part_o,
    output logic             led_stop_o,
    output logic             err_under_o,
    output logic             err_over_o,
    output logic             save_err_o,
    output logic             menu_open_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    vpc_regs_t   r;
    vpc_regs_t   n;

    logic        ms_tick;
    logic [1:0]  in_raw;
    logic        wb_req;
    logic        wb_wr;
    logic [5:0]  idx;
    logic        wr_en;
    logic        remote_wr;
    logic [5:0]  wr_idx;
    logic [15:0] wr_dat;
    logic [1:0]  wr_lane;
    logic [13:0] stop_prod;
    logic [9:0]  stop_lo;
    logic [9:0]  part_lo;
    logic [31:0] status;
    logic [31:0] rd;

    // Byte-lane merge for the 16-bit parameter words
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] val,
                                          input logic [1:0]  lane);
        logic [15:0] m;
        m = old;
        if (lane[0]) begin
            m[7:0] = val[7:0];
        end
        if (lane[1]) begin
            m[15:8] = val[15:8];
        end
        return m;
    endfunction

    always_comb begin
        n = r;

        // ------------------------------------------------------------
        // Time base and input filter
        // ------------------------------------------------------------
        ms_tick = (r.ms_cnt == 16'(P_CYC_PER_MS - 1));
        n.ms_cnt = ms_tick ? '0 : r.ms_cnt + 16'h0001;

        // NPN inputs are active when the line is pulled low
        in_raw = {blowoff_i, suction_i} ^ {2{~r.ctrl[CTRL_NPN]}} ^ 2'h3;
        for (int i = 0; i < 2; i++) begin
            if (in_raw[i] == r.in_act[i]) begin
                n.flt_cnt[2*i +: 2] = 2'h0;
            end else if (ms_tick) begin
                if (r.flt_cnt[2*i +: 2] == 2'(IN_REACT_MS - 1)) begin
                    n.in_act[i] = in_raw[i];
                    n.flt_cnt[2*i +: 2] = 2'h0;
                end else begin
                    n.flt_cnt[2*i +: 2] = r.flt_cnt[2*i +: 2] + 2'h1;
                end
            end
        end

        // ------------------------------------------------------------
        // One vacuum sample feeds every comparison
        // ------------------------------------------------------------
        n.vac = vacuum_i;
        stop_prod = 14'(r.thr_stop) * BAND_NUM;
        stop_lo = 10'(stop_prod / BAND_DEN);
        part_lo = (r.thr_part > r.hyst) ? r.thr_part - r.hyst : '0;

        // Threshold levels, from vacuum alone
        if (r.vac > r.thr_stop) begin
            n.lvl_stop = 1'b1;
        end else if (r.vac < stop_lo) begin
            n.lvl_stop = 1'b0;
        end
        if (r.vac > r.thr_part) begin
            n.lvl_part = 1'b1;
        end else if (r.vac < part_lo) begin
            n.lvl_part = 1'b0;
        end

        // ------------------------------------------------------------
        // Operating sequence
        // ------------------------------------------------------------
        case (r.st)
            VPC_IDLE: begin
                if (r.in_act[1]) begin
                    n.st = VPC_BLOW;
                    n.blow_cnt = '0;
                end else if (r.in_act[0]) begin
                    n.st = VPC_SUCK;
                end
            end
            VPC_SUCK, VPC_HOLD: begin
                if (r.in_act[1]) begin
                    n.st = VPC_BLOW;
                    n.blow_cnt = '0;
                end else if (!r.in_act[0]) begin
                    n.blow_cnt = '0;
                    n.st = r.ctrl[CTRL_BLOINT] ? VPC_BLOW
                                               : VPC_IDLE;
                end else if (r.st == VPC_SUCK && r.vac >= r.thr_stop) begin
                    n.st = VPC_HOLD;
                end else if (r.st == VPC_HOLD && r.vac < stop_lo) begin
                    n.st = VPC_SUCK;
                end
            end
            VPC_BLOW: begin
                if (ms_tick && r.blow_cnt != 16'hFFFF) begin
                    n.blow_cnt = r.blow_cnt + 16'h0001;
                end
                // External venting ends with the input; internal on time
                if (r.in_act[1]) begin
                    n.st = VPC_BLOW;
                end else if (!r.ctrl[CTRL_BLOINT] || (ms_tick
                             && r.blow_cnt >= r.blow_ms)) begin
                    n.st = r.in_act[0] ? VPC_SUCK : VPC_IDLE;
                end
            end
            default: begin
                n.st = VPC_IDLE;
            end
        endcase

        n.pump = (n.st == VPC_SUCK);
        n.valve = (n.st == VPC_BLOW);
        n.led_suck = (n.st == VPC_SUCK) || (n.st == VPC_HOLD);
        n.led_blow = (n.st == VPC_BLOW);

        // ------------------------------------------------------------
        // Threshold LEDs, flashing in manual mode
        // ------------------------------------------------------------
        if (ms_tick) begin
            if (r.flash_cnt == 8'(FLASH_MS - 1)) begin
                n.flash_cnt = '0;
                n.flash = ~r.flash;
            end else begin
                n.flash_cnt = r.flash_cnt + 8'h01;
            end
        end
        if (r.ctrl[CTRL_MANUAL]) begin
            n.led_part = r.flash;
            n.led_stop = r.flash;
        end else begin
            n.led_part = r.lvl_part | r.lvl_stop;
            n.led_stop = r.lvl_stop;
        end

        // ------------------------------------------------------------
        // Second switch output with response delay
        // ------------------------------------------------------------
        if (r.lvl_part == r.second_switch_output) begin
            n.out_cnt = '0;
        end else if (ms_tick) begin
            // Zero or oversize settings are clamped into 1..200 ms
            if (r.out_cnt + 8'h01 >= ((r.dly_ms < DLY_MIN) ? DLY_MIN :
                (r.dly_ms > DLY_MAX) ? DLY_MAX : r.dly_ms)) begin
                n.second_switch_output = r.lvl_part;
                n.out_cnt = '0;
            end else begin
                n.out_cnt = r.out_cnt + 8'h01;
            end
        end
        n.second_switch_output_pin = n.second_switch_output ^ r.ctrl[CTRL_NPN];

        // Pump-on time for the energy monitoring data
        if (ms_tick && r.pump) begin
            n.energy_ms = r.energy_ms + 32'h0000_0001;
        end

        // ------------------------------------------------------------
        // Supply supervision
        // ------------------------------------------------------------
        n.under = (supply_mv_i < UNDER_MV);
        n.over = (supply_mv_i > OVER_MV);

        // ------------------------------------------------------------
        // Parameter writes: link first, panel only without session
        // ------------------------------------------------------------
        wb_req = wb_cyc_i && wb_stb_i && !r.ack;
        wb_wr = wb_req && wb_we_i;
        idx = wb_adr_i[7:2];
        if (wb_wr) begin
            wr_en = 1'b1;
            wr_idx = idx;
            wr_dat = wb_dat_i[15:0];
            wr_lane = wb_sel_i[1:0];
        end else begin
            // A panel write in the same cycle as a bus write is dropped
            wr_en = panel_we_i && !link_active_i;
            wr_idx = panel_idx_i;
            wr_dat = panel_dat_i;
            wr_lane = 2'h3;
        end
        remote_wr = 1'b0;
        if (wr_en) begin
            remote_wr = wb_wr;
            case (wr_idx)
                IDX_CTRL: n.ctrl = 3'(merge(16'(r.ctrl), wr_dat, wr_lane));
                IDX_STOP: n.thr_stop = 10'(merge(16'(r.thr_stop), wr_dat,
                                                 wr_lane));
                IDX_PART: n.thr_part = 10'(merge(16'(r.thr_part), wr_dat,
                                                 wr_lane));
                IDX_HYST: n.hyst = 10'(merge(16'(r.hyst), wr_dat, wr_lane));
                IDX_BLOW: n.blow_ms = merge(r.blow_ms, wr_dat, wr_lane);
                IDX_DLY:  n.dly_ms = 8'(merge(16'(r.dly_ms), wr_dat,
                                              wr_lane));
                default: remote_wr = 1'b0;
            endcase
        end

        // ------------------------------------------------------------
        // Save window after a remote or wireless change
        // ------------------------------------------------------------
        if (remote_wr || wireless_write_i) begin
            n.win_cnt = 16'(P_SAVE_MS);
        end else if (ms_tick && r.win_cnt != '0) begin
            n.win_cnt = r.win_cnt - 16'h0001;
        end
        // Clear by writing one; a new error in the same cycle wins
        if (wb_wr && idx == IDX_STATUS && wb_sel_i[0]
            && wb_dat_i[STAT_SAVE]) begin
            n.save_err = 1'b0;
        end
        if (power_fail_i && r.win_cnt != '0) begin
            n.save_err = 1'b1;
        end

        // ------------------------------------------------------------
        // Menu idle timeout
        // ------------------------------------------------------------
        if (panel_key_i || (panel_we_i && !link_active_i)) begin
            n.menu_open = 1'b1;
            n.menu_cnt = '0;
        end else if (r.menu_open && ms_tick) begin
            if (r.menu_cnt == 16'(P_MENU_MS - 1)) begin
                n.menu_open = 1'b0;
                n.menu_cnt = '0;
            end else begin
                n.menu_cnt = r.menu_cnt + 16'h0001;
            end
        end

        // ------------------------------------------------------------
        // Wishbone read and acknowledge
        // ------------------------------------------------------------
        status = {16'h0000, 4'(r.st), 3'h0, r.menu_open, r.second_switch_output,
                  r.save_err, r.over, r.under, r.led_stop, r.led_part,
                  r.valve, r.pump};
        case (idx)
            IDX_CTRL:   rd = 32'(r.ctrl);
            IDX_STOP:   rd = 32'(r.thr_stop);
            IDX_PART:   rd = 32'(r.thr_part);
            IDX_HYST:   rd = 32'(r.hyst);
            IDX_BLOW:   rd = 32'(r.blow_ms);
            IDX_DLY:    rd = 32'(r.dly_ms);
            IDX_STATUS: rd = status;
            IDX_VAC:    rd = 32'(r.vac);
            IDX_SUPPLY: rd = 32'(supply_mv_i);
            IDX_ENERGY: rd = r.energy_ms;
            default:    rd = '0;
        endcase
        n.ack = wb_req;
        n.dat = wb_req ? rd : '0;
    end

    // ----------------------------------------------------------------
    // Register stage
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r          <= '0;
            r.st       <= VPC_IDLE;
            r.ctrl     <= CTRL_RST;
            r.thr_stop <= STOP_RST;
            r.thr_part <= PART_RST;
            r.hyst     <= HYST_RST;
            r.blow_ms  <= BLOW_RST;
            r.dly_ms   <= DLY_RST;
        end else begin
            r <= n;
        end
    end

    assign wb_dat_o      = r.dat;
    assign wb_ack_o      = r.ack;
    assign pump_o        = r.pump;
    assign valve_o       = r.valve;
    assign second_switch_output_o        = r.second_switch_output_pin;
    assign led_suction_o = r.led_suck;
    assign led_blowoff_o = r.led_blow;
    assign led_part_o    = r.led_part;
    assign led_stop_o    = r.led_stop;
    assign err_under_o   = r.under;
    assign err_over_o    = r.over;
    assign save_err_o    = r.save_err;
    assign menu_open_o   = r.menu_open;

endmodule // vpc_top

// ---- verification/vpc_top_monitor.sv ----
// Concurrent checks on the vacuum pump controller ports
`timescale 1ns/10ps
module vpc_top_monitor (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic [15:0] supply_mv_i,
    input wire logic        power_fail_i,
    input wire logic        pump_o,
    input wire logic        valve_o,
    input wire logic        led_suction_o,
    input wire logic        led_blowoff_o,
    input wire logic        led_part_o,
    input wire logic        led_stop_o,
    input wire logic        err_under_o,
    input wire logic        err_over_o,
    input wire logic        save_err_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------
    // Sequences and assertions
    // ------------------------------------------------------------
    sequence wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence under_run;
        (supply_mv_i < 16'h4B00) [*3];
    endsequence
    sequence over_run;
        (supply_mv_i > 16'h6720) [*3];
    endsequence
    ack_after_req_a: assert property (wb_req |=> wb_ack_o)
        else $error("request not answered next cycle");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    blow_wins_a: assert property (valve_o |-> !pump_o)
        else $error("pump on while venting");
    blow_led_a: assert property ($rose(valve_o) |-> ##[0:2] led_blowoff_o)
        else $error("blowoff lamp missing");
    suck_led_a: assert property (pump_o |-> ##[0:2] led_suction_o)
        else $error("suction lamp missing");
    stop_part_a: assert property (led_stop_o |-> led_part_o)
        else $error("stop lamp without part lamp");
    under_flag_a: assert property (under_run |-> err_under_o)
        else $error("low supply not flagged");
    over_flag_a: assert property (over_run |-> err_over_o)
        else $error("high supply not flagged");
    save_cause_a: assert property ($rose(save_err_o) |->
        $past(power_fail_i) || $past(power_fail_i, 2))
        else $error("save error without power loss");
endmodule // vpc_top_monitor

bind vpc_top vpc_top_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .supply_mv_i(supply_mv_i),
    .power_fail_i(power_fail_i), .pump_o(pump_o), .valve_o(valve_o),
    .led_suction_o(led_suction_o), .led_blowoff_o(led_blowoff_o),
    .led_part_o(led_part_o), .led_stop_o(led_stop_o),
    .err_under_o(err_under_o), .err_over_o(err_over_o),
    .save_err_o(save_err_o));

// ---- verification/vpc_plc_model.sv ----
// Controller-side model driving the discrete suction and blowoff pins
`timescale 1ns/10ps
module vpc_plc_model (
    input  wire logic clk_i,
    input  wire logic suck_cmd_i,
    input  wire logic blow_cmd_i,
    input  wire logic npn_i,
    output logic      suction_o,
    output logic      blowoff_o
);
    // Sinking wiring inverts the pin; registered like an output card
    always_ff @(posedge clk_i) begin
        suction_o <= suck_cmd_i ^ npn_i;
        blowoff_o <= blow_cmd_i ^ npn_i;
    end
endmodule // vpc_plc_model

// ---- verification/vacuum_pump_controller_tb.sv ----
// Self-checking testbench of the vacuum pump controller
`timescale 1ns/10ps
module vacuum_pump_controller_tb;
    import vpc_pkg::*;
    localparam int P = 8;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, dat_o, rd;
    logic [9:0]  vac = 10'h000;
    logic [15:0] sup = 16'h5DC0;
    logic        ack, suck_cmd = 0, blow_cmd = 0, npn = 0, s_pin, b_pin;
    logic        pfail = 0, wl_wr = 0, pump, valve, led_s, led_b, led_p;
    logic        led_t, e_un, e_ov, s_err;
    logic        lnk = 0, pkey = 0, pwe = 0, o2, mo;
    logic [5:0]  pidx = 6'h00;
    logic [15:0] pdat = 16'h0000;
    logic [15:0] dv [0:5] = '{16'h0000, 16'h0226, 16'h0190, 16'h0014,
                              16'h00C8, 16'h000A};
    int          fails = 0, num_checks = 0, n;

    always #10 clk_i = ~clk_i;

    vpc_top #(.P_CYC_PER_MS(P), .P_SAVE_MS(5), .P_MENU_MS(4)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(4'h3), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .suction_i(s_pin),
        .blowoff_i(b_pin), .vacuum_i(vac), .supply_mv_i(sup),
        .power_fail_i(pfail), .link_active_i(lnk),
        .wireless_write_i(wl_wr), .panel_key_i(pkey), .panel_we_i(pwe),
        .panel_idx_i(pidx), .panel_dat_i(pdat), .pump_o(pump),
        .valve_o(valve), .second_switch_output_o(o2), .led_suction_o(led_s),
        .led_blowoff_o(led_b), .led_part_o(led_p), .led_stop_o(led_t),
        .err_under_o(e_un), .err_over_o(e_ov), .save_err_o(s_err),
        .menu_open_o(mo));

    vpc_plc_model plc (.clk_i(clk_i), .suck_cmd_i(suck_cmd),
        .blow_cmd_i(blow_cmd), .npn_i(npn), .suction_o(s_pin),
        .blowoff_o(b_pin));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task print_verdict;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wb(input logic w, input logic [5:0] idx, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= {idx, 2'b00}; wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = dat_o;
        cyc <= 0; stb <= 0; we <= 0;
        if (n >= 50) begin
            fails++;
            print_verdict;
        end
    endtask
    task tick(input int c);
        repeat (c) @(posedge clk_i);
    endtask
    // Bounded wait; running out counts as a mismatch
    task wait_out(input bit which, input logic v);
        n = 0;
        num_checks++;
        while (((which ? valve : pump) !== v) && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 200) begin
            fails++;
            print_verdict;
        end
    endtask

    initial begin
        tick(10);
        rst_i <= 0;
        for (int i = 0; i < 6; i++) begin
            wb(0, 6'(i), 32'h0);
            chk(rd, {16'h0, dv[i]});
        end
        wb(0, 6'h3F, 32'h0);
        chk(rd, 32'h0);
        sup <= 16'h4AFF; tick(4); chk(e_un, 1);
        sup <= 16'h6721; tick(4); chk({e_un, e_ov}, 2'b01);
        sup <= 16'h5DC0;
        suck_cmd <= 1; tick(2 * P); chk(pump, 0);
        wait_out(0, 1);
        vac <= 10'h191; tick(5); chk({led_s, led_p, led_t}, 3'b110);
        vac <= 10'h226; tick(5); chk({pump, led_s, led_t}, 3'b010);
        vac <= 10'h227; tick(5); chk({led_p, led_t}, 2'b11);
        vac <= 10'h1EF; tick(5); chk({pump, led_t}, 2'b01);
        vac <= 10'h1EE; tick(5); chk({pump, led_p, led_t}, 3'b110);
        vac <= 10'h17C; tick(5); chk(led_p, 1);
        vac <= 10'h17B; tick(5); chk({led_p, led_t}, 2'b00);
        wb(0, IDX_VAC, 32'h0); chk(rd, 32'h17B);
        blow_cmd <= 1; wait_out(1, 1);
        chk({pump, led_b}, 2'b01);
        blow_cmd <= 0; wait_out(1, 0);
        wait_out(0, 1);
        suck_cmd <= 0; wait_out(0, 0);
        tick(50); chk({valve, led_s, led_b}, 3'b000);
        wb(1, IDX_BLOW, 32'h3);
        wb(1, IDX_CTRL, 32'h2);
        suck_cmd <= 1; wait_out(0, 1);
        suck_cmd <= 0; wait_out(1, 1);
        n = 0;
        while (valve === 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        chk(32'(n >= 3 * P && n <= 4 * P + 2), 32'h1);
        wb(1, IDX_CTRL, 32'h1);
        npn <= 1;
        suck_cmd <= 1; wait_out(0, 1);
        suck_cmd <= 0; wait_out(0, 0);
        wb(1, IDX_CTRL, 32'h0);
        npn <= 0;
        tick(60);
        wl_wr <= 1; tick(1); wl_wr <= 0; tick(2);
        pfail <= 1; tick(1); pfail <= 0; tick(3);
        chk(s_err, 1);
        wb(0, IDX_STATUS, 32'h0); chk(rd[STAT_SAVE], 1);
        wb(1, IDX_STATUS, 32'h40); tick(2); chk(s_err, 0);
        tick(60);
        pfail <= 1; tick(1); pfail <= 0; tick(3);
        chk(s_err, 0);
        lnk <= 1; pwe <= 1; pidx <= IDX_DLY; pdat <= 16'h0005;
        tick(1); pwe <= 0; tick(2); chk(mo, 0);
        wb(0, IDX_DLY, 32'h0); chk(rd, 32'hA);
        lnk <= 0; pwe <= 1; tick(1); pwe <= 0; tick(2); chk(mo, 1);
        wb(0, IDX_DLY, 32'h0); chk(rd, 32'h5);
        tick(16); chk(mo, 1); tick(20); chk(mo, 0);
        pkey <= 1; tick(1); pkey <= 0; tick(2); chk(mo, 1);
        vac <= 10'h191; tick(4 * P); chk(o2, 0);
        tick(2 * P); chk(o2, 1);
        wb(1, IDX_CTRL, 32'h4); tick(3); chk(led_t, led_p);
        rd[0] = led_p; tick(FLASH_MS * P);
        chk({led_p, led_t}, {2{~rd[0]}});
        wb(1, IDX_CTRL, 32'h1); tick(2); chk(o2, 0);
        print_verdict;
    end
endmodule // vacuum_pump_controller_tb
